/* usb_ep0_pkg.sv */
// Constants and types shared by the control endpoint handshake block
package usb_ep0_pkg;

	// ----------------------------------------------------------------
	// Register map (byte addresses)
	// ----------------------------------------------------------------
	localparam int ADDR_W = 8;
	localparam logic [ADDR_W-1:0] CTRL_OFFSET = 8'h18;
	localparam logic [ADDR_W-1:0] STATUS_OFFSET = 8'h30;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int ENABLE_BIT = 31;
	localparam int STATE_HI = 30;
	localparam int STATE_LO = 29;
	localparam int IN_STALL_BIT = 28;
	localparam int OUT_STALL_BIT = 27;
	localparam int COUNT_W = 7;
	localparam int COUNT_MSB = 6;
	localparam int STATUS_REPLY_LSB = 0;
	localparam int STATUS_REPLY_MSB = 2;
	localparam int STATUS_PHASE_LSB = 4;
	localparam int STATUS_PHASE_MSB = 5;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		HS_NAK = 2'h0,
		HS_ACK = 2'h1,
		HS_STALL = 2'h2,
		HS_STALL_ALT = 2'h3
	} hs_state_t;

	typedef enum logic [1:0] {
		TOK_SETUP = 2'h0,
		TOK_IN = 2'h1,
		TOK_OUT = 2'h2,
		TOK_OTHER = 2'h3
	} token_kind_t;

	typedef enum logic [2:0] {
		REPLY_NONE = 3'h0,
		REPLY_NAK = 3'h1,
		REPLY_ACK = 3'h2,
		REPLY_DATA = 3'h3,
		REPLY_STALL = 3'h4
	} reply_t;

	typedef enum logic [1:0] {
		PH_IDLE = 2'h0,
		PH_SETUP_DATA = 2'h1,
		PH_OUT_DATA = 2'h3,
		PH_IN_ACK = 2'h2
	} phase_t;

	typedef struct packed {
		logic endpoint_function_on;
		hs_state_t handshake_state;
		logic in_stall;
		logic out_stall;
		logic [COUNT_W-1:0] byte_count;
	} ctrl_t;

	typedef struct packed {
		logic valid;
		logic control_endpoint;
		token_kind_t kind;
	} token_t;

	typedef struct packed {
		logic done;
		logic [COUNT_W-1:0] count;
	} rx_data_t;

	typedef struct packed {
		logic valid;
		reply_t code;
		logic [COUNT_W-1:0] count;
	} reply_out_t;

endpackage : usb_ep0_pkg

/* handshake_select.sv */
// Handshake choice for one token on the control endpoint
`timescale 1ns/1ns
module handshake_select (
	// Endpoint settings
	input wire usb_ep0_pkg::ctrl_t ctrl,
	// Token
	input wire usb_ep0_pkg::token_kind_t kind,
	// Choice
	output usb_ep0_pkg::reply_t code
);

	always_comb begin
		code = usb_ep0_pkg::REPLY_NONE;
		if (ctrl.endpoint_function_on) begin
			case (kind)
				usb_ep0_pkg::TOK_SETUP: begin
					code = usb_ep0_pkg::REPLY_ACK;
				end
				usb_ep0_pkg::TOK_IN: begin
					// Only the IN stall bit and the state matter
					if (ctrl.in_stall) begin
						code = usb_ep0_pkg::REPLY_STALL;
					end else begin
						case (ctrl.handshake_state)
							usb_ep0_pkg::HS_NAK: code = usb_ep0_pkg::REPLY_NAK;
							usb_ep0_pkg::HS_ACK: code = usb_ep0_pkg::REPLY_DATA;
							default: code = usb_ep0_pkg::REPLY_STALL;
						endcase
					end
				end
				usb_ep0_pkg::TOK_OUT: begin
					// Only the OUT stall bit and the state matter
					if (ctrl.out_stall) begin
						code = usb_ep0_pkg::REPLY_STALL;
					end else begin
						case (ctrl.handshake_state)
							usb_ep0_pkg::HS_NAK: code = usb_ep0_pkg::REPLY_NAK;
							usb_ep0_pkg::HS_ACK: code = usb_ep0_pkg::REPLY_ACK;
							default: code = usb_ep0_pkg::REPLY_STALL;
						endcase
					end
				end
				default: begin
					code = usb_ep0_pkg::REPLY_NONE;
				end
			endcase
		end
	end

endmodule : handshake_select

/* apb_decode.sv */
// APB address decode and read data selection
`timescale 1ns/1ns
module apb_decode #(
	parameter int ADDR_W = usb_ep0_pkg::ADDR_W
) (
	// APB request
	input wire logic [ADDR_W-1:0] paddr,
	// Register contents
	input wire logic [31:0] ctrl_word,
	input wire logic [31:0] status_word,
	// Decode results
	output logic ctrl_hit,
	output logic unmapped,
	output logic [31:0] rd_data
);

	always_comb begin
		ctrl_hit = 1'b0;
		unmapped = 1'b0;
		rd_data = 32'h0000_0000;
		if (paddr == usb_ep0_pkg::CTRL_OFFSET) begin
			ctrl_hit = 1'b1;
			rd_data = ctrl_word;
		end else if (paddr == usb_ep0_pkg::STATUS_OFFSET) begin
			rd_data = status_word;
		end else begin
			unmapped = 1'b1;
		end
	end

endmodule : apb_decode

/* usb_control_endpoint_handshake.sv */
// Control endpoint handshake logic with its APB register file
//
// Notes on behaviour
// - With the function bit (31) low, SETUP, IN and OUT get no handshake.
// - State 01 with no stall answers an IN token with a data packet.
// - State 01 accepts an OUT token and its data and answers ACK.
// - Handshake state 10 or 11 answers both IN and OUT tokens with STALL.
// - A completed setup transaction returns the handshake state to NAK (00).
// - The IN stall bit (28) makes IN transactions answer STALL.
// - The OUT stall bit (27) makes OUT tokens answer STALL and leaves IN alone.
// - IN uses its stall bit and the state only; OUT likewise its own.
// - A completed setup transaction clears both stall bits to 0.
// - For IN, the seven-bit count (bits 6:0) is the number of bytes to send.
// - For OUT, the seven-bit count is overwritten with the bytes received.
//
// Implementation choice: the APB slave port.
`timescale 1ns/1ns
module usb_control_endpoint_handshake #(
	parameter int ADDR_W = usb_ep0_pkg::ADDR_W,
	parameter int COUNT_W = usb_ep0_pkg::COUNT_W
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Tokens from the link
	input wire usb_ep0_pkg::token_t token,
	// Data packet accepted from the host
	input wire usb_ep0_pkg::rx_data_t rx_data,
	// Host acknowledged our data packet
	input wire logic host_ack,
	// Handshake choice to the link
	output usb_ep0_pkg::reply_out_t reply
);

	// ----------------------------------------------------------------
	// Elaboration checks
	// ----------------------------------------------------------------
	if (COUNT_W != usb_ep0_pkg::COUNT_W) begin : g_count_check
		$error("byte count width must match the register field");
	end
	if (ADDR_W < usb_ep0_pkg::ADDR_W) begin : g_addr_check
		$error("address too narrow for the register map");
	end

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		usb_ep0_pkg::ctrl_t ctrl;
		usb_ep0_pkg::phase_t phase;
		usb_ep0_pkg::reply_t last_reply;
		usb_ep0_pkg::reply_out_t reply;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} state_t;

	state_t state_q;
	state_t state_d;

	logic [31:0] ctrl_word;
	logic [31:0] status_word;
	logic ctrl_hit;
	logic unmapped;
	logic [31:0] rd_data;
	usb_ep0_pkg::reply_t choice;
	logic apb_setup;
	logic apb_access;
	logic tok_here;

	// ----------------------------------------------------------------
	// Register images
	// ----------------------------------------------------------------
	always_comb begin
		ctrl_word = usb_ep0_pkg::CTRL_RESET;
		ctrl_word[usb_ep0_pkg::ENABLE_BIT] =
			state_q.ctrl.endpoint_function_on;
		ctrl_word[usb_ep0_pkg::STATE_HI:usb_ep0_pkg::STATE_LO] =
			state_q.ctrl.handshake_state;
		ctrl_word[usb_ep0_pkg::IN_STALL_BIT] = state_q.ctrl.in_stall;
		ctrl_word[usb_ep0_pkg::OUT_STALL_BIT] = state_q.ctrl.out_stall;
		ctrl_word[usb_ep0_pkg::COUNT_MSB:0] = state_q.ctrl.byte_count;
	end

	always_comb begin
		status_word = 32'h0000_0000;
		status_word[usb_ep0_pkg::STATUS_REPLY_MSB:
			usb_ep0_pkg::STATUS_REPLY_LSB] = state_q.last_reply;
		status_word[usb_ep0_pkg::STATUS_PHASE_MSB:
			usb_ep0_pkg::STATUS_PHASE_LSB] = state_q.phase;
	end

	// ----------------------------------------------------------------
	// Submodules
	// ----------------------------------------------------------------
	apb_decode #(
		.ADDR_W(ADDR_W)
	) u_decode (
		.paddr(paddr),
		.ctrl_word(ctrl_word),
		.status_word(status_word),
		.ctrl_hit(ctrl_hit),
		.unmapped(unmapped),
		.rd_data(rd_data)
	);

	handshake_select u_select (
		.ctrl(state_q.ctrl),
		.kind(token.kind),
		.code(choice)
	);

	assign apb_setup = psel && !penable;
	assign apb_access = psel && penable && state_q.pready;
	// Tokens of the other kind are ignored and get no reply
	assign tok_here = token.valid && token.control_endpoint &&
		(token.kind != usb_ep0_pkg::TOK_OTHER);

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		state_d = state_q;
		state_d.reply.valid = 1'b0;

		// APB: answer in the cycle after setup, no wait states
		if (apb_setup) begin
			state_d.pready = 1'b1;
			state_d.prdata = pwrite ? 32'h0000_0000 : rd_data;
			state_d.pslverr = unmapped;
		end else if (apb_access) begin
			state_d.pready = 1'b0;
			state_d.pslverr = 1'b0;
			if (pwrite && ctrl_hit) begin
				state_d.ctrl.endpoint_function_on =
					pwdata[usb_ep0_pkg::ENABLE_BIT];
				state_d.ctrl.handshake_state = usb_ep0_pkg::hs_state_t'(
					pwdata[usb_ep0_pkg::STATE_HI:usb_ep0_pkg::STATE_LO]);
				state_d.ctrl.in_stall = pwdata[usb_ep0_pkg::IN_STALL_BIT];
				state_d.ctrl.out_stall = pwdata[usb_ep0_pkg::OUT_STALL_BIT];
				state_d.ctrl.byte_count = pwdata[usb_ep0_pkg::COUNT_MSB:0];
			end
		end else begin
			state_d.pready = 1'b0;
		end

		// Link events are applied after software, so hardware wins
		case (state_q.phase)
			usb_ep0_pkg::PH_SETUP_DATA: begin
				if (rx_data.done) begin
					state_d.ctrl.handshake_state = usb_ep0_pkg::HS_NAK;
					state_d.ctrl.in_stall = 1'b0;
					state_d.ctrl.out_stall = 1'b0;
					state_d.phase = usb_ep0_pkg::PH_IDLE;
				end
			end
			usb_ep0_pkg::PH_OUT_DATA: begin
				if (rx_data.done) begin
					state_d.ctrl.byte_count = rx_data.count;
					state_d.ctrl.handshake_state = usb_ep0_pkg::HS_NAK;
					state_d.phase = usb_ep0_pkg::PH_IDLE;
				end
			end
			usb_ep0_pkg::PH_IN_ACK: begin
				if (host_ack) begin
					state_d.ctrl.handshake_state = usb_ep0_pkg::HS_NAK;
					state_d.phase = usb_ep0_pkg::PH_IDLE;
				end
			end
			default: begin
				state_d.phase = usb_ep0_pkg::PH_IDLE;
			end
		endcase

		// A new token starts a fresh transaction
		if (tok_here) begin
			state_d.reply.valid = 1'b1;
			state_d.reply.code = choice;
			state_d.reply.count = state_q.ctrl.byte_count;
			state_d.last_reply = choice;
			state_d.phase = usb_ep0_pkg::PH_IDLE;
			if (choice == usb_ep0_pkg::REPLY_DATA) begin
				state_d.phase = usb_ep0_pkg::PH_IN_ACK;
			end else if (choice == usb_ep0_pkg::REPLY_ACK) begin
				if (token.kind == usb_ep0_pkg::TOK_SETUP) begin
					state_d.phase = usb_ep0_pkg::PH_SETUP_DATA;
				end else begin
					state_d.phase = usb_ep0_pkg::PH_OUT_DATA;
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (reset) begin
			state_q <= '0;
		end else begin
			state_q <= state_d;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign prdata = state_q.prdata;
	assign pready = state_q.pready;
	assign pslverr = state_q.pslverr;
	assign reply = state_q.reply;

endmodule : usb_control_endpoint_handshake

/* usb_ep0_chk.sv */
// Port assertions for the control endpoint handshake block
`timescale 1ns/1ns
module usb_ep0_chk #(
	parameter int ADDR_W = 8,
	parameter int COUNT_W = 7
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// APB
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// Link
	input wire usb_ep0_pkg::token_t token,
	input wire usb_ep0_pkg::reply_out_t reply
);
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	logic ep;
	logic tok_ok;
	assign ep = token.valid && token.control_endpoint;
	assign tok_ok = ep && token.kind != 2'h3;

	a_reply_follows: assert property (tok_ok |=> reply.valid)
		else $error("reply missing after token");
	a_reply_cause: assert property (reply.valid |-> $past(tok_ok))
		else $error("reply without token");
	a_setup_ack: assert property (ep && token.kind == 2'h0
		|=> reply.code inside {3'h0, 3'h2})
		else $error("setup reply not ACK or none");
	a_in_code: assert property (ep && token.kind == 2'h1
		|=> reply.code != 3'h2)
		else $error("IN token answered ACK");
	a_out_code: assert property (ep && token.kind == 2'h2
		|=> reply.code != 3'h3)
		else $error("OUT token answered with data");
	a_pready_ans: assert property (psel && !penable |=> pready)
		else $error("pready late");
	a_pready_pulse: assert property (pready |=> !pready)
		else $error("pready held");
	a_slverr_map: assert property (pready |->
		pslverr == !(paddr inside {8'h18, 8'h30}))
		else $error("pslverr wrong for address");
	a_rsvd_zero: assert property (pready && !pwrite && paddr == 8'h18
		|-> prdata[26:7] == 20'h0)
		else $error("reserved bits not zero");
	a_err_data: assert property (pslverr |-> prdata == 32'h0)
		else $error("error read data not zero");
endmodule : usb_ep0_chk

bind usb_control_endpoint_handshake usb_ep0_chk #(.ADDR_W(ADDR_W),
	.COUNT_W(COUNT_W)) i_usb_ep0_chk (.clk(clk), .reset(reset),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.prdata(prdata), .pready(pready), .pslverr(pslverr),
	.token(token), .reply(reply));

/* host_model.sv */
// Host side model sending tokens, data and acknowledges
`timescale 1ns/1ns
module host_model (
	// Clock
	input wire logic clk,
	// Link
	output usb_ep0_pkg::token_t token,
	output usb_ep0_pkg::rx_data_t rx_data,
	output logic host_ack,
	input wire usb_ep0_pkg::reply_out_t reply
);
	initial begin
		token = '0;
		rx_data = '0;
		host_ack = 1'b0;
	end
	// Idle fields show the inverse of the last value
	task automatic tok(input logic [1:0] k, input logic ep,
		output usb_ep0_pkg::reply_out_t r);
		@(posedge clk);
		token <= usb_ep0_pkg::token_t'({1'b1, ep, k});
		@(posedge clk);
		token <= usb_ep0_pkg::token_t'({1'b0, ~ep, ~k});
		@(posedge clk);
		r = reply;
	endtask : tok
	task automatic data(input logic [6:0] n);
		@(posedge clk);
		rx_data <= '{1'b1, n};
		@(posedge clk);
		rx_data <= '{1'b0, ~n};
	endtask : data
	task automatic ack();
		@(posedge clk);
		host_ack <= 1'b1;
		@(posedge clk);
		host_ack <= 1'b0;
	endtask : ack
endmodule : host_model

/* tb_top.sv */
// Self-checking bench for the control endpoint handshake block
`timescale 1ns/1ns
module tb_top;
	logic clk, reset, psel, penable, pwrite, pready, pslverr, host_ack, err;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	usb_ep0_pkg::token_t token;
	usb_ep0_pkg::rx_data_t rx_data;
	usb_ep0_pkg::reply_out_t reply, r;
	int mismatches = 0;
	int comparisons = 0;

	usb_control_endpoint_handshake i_usb_control_endpoint_handshake (
		.clk(clk), .reset(reset), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .token(token),
		.rx_data(rx_data), .host_ack(host_ack), .reply(reply));
	host_model i_host_model (.clk(clk), .token(token), .rx_data(rx_data),
		.host_ack(host_ack), .reply(reply));

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	task automatic check(input string n, input logic [31:0] e,
		input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			$display("ERROR %s expected %h seen %h", n, e, g);
			mismatches++;
		end
	endtask : check
	task automatic print_verdict();
		$display("compared %0d, wrong %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : print_verdict
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int i;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		for (i = 0; i < 16; i++) begin
			@(posedge clk);
			if (pready === 1'b1)
				break;
		end
		if (i == 16) begin
			mismatches++;
			print_verdict();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic tx(input logic [1:0] k, input logic [2:0] c);
		i_host_model.tok(k, 1'b1, r);
		check("reply valid", 32'h1, {31'h0, r.valid});
		check("reply code", {29'h0, c}, {29'h0, r.code});
	endtask : tx

	initial begin
		reset = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		repeat (16) @(posedge clk);
		reset <= 1'b0;
		apb(1'b0, 8'h18, 32'h0);
		check("ctrl reset", 32'h0, rd);
		apb(1'b0, 8'h40, 32'h0);
		check("unmapped", 32'h1, {31'h0, err});
		for (int k = 0; k < 3; k++)
			tx(k[1:0], 3'h0);
		$display("done: reset and disabled");
		apb(1'b1, 8'h18, 32'hA000_0005);
		i_host_model.tok(2'h3, 1'b1, r);
		check("other kind", 32'h0, {31'h0, r.valid});
		i_host_model.tok(2'h1, 1'b0, r);
		check("other endpoint", 32'h0, {31'h0, r.valid});
		tx(2'h1, 3'h3);
		check("in count", 32'h5, {25'h0, r.count});
		i_host_model.ack();
		tx(2'h1, 3'h1);
		apb(1'b1, 8'h18, 32'hA000_0000);
		tx(2'h2, 3'h2);
		apb(1'b0, 8'h30, 32'h0);
		check("status out wait", 32'h0000_0032, rd);
		i_host_model.data(7'h2B);
		apb(1'b0, 8'h18, 32'h0);
		check("out count", 32'h8000_002B, rd);
		$display("done: data and ack");
		for (int s = 2; s < 4; s++) begin
			apb(1'b1, 8'h18, {1'b1, s[1:0], 29'h0});
			tx(2'h1, 3'h4);
			tx(2'h2, 3'h4);
		end
		apb(1'b1, 8'h18, 32'hB000_0000);
		tx(2'h1, 3'h4);
		tx(2'h2, 3'h2);
		apb(1'b1, 8'h18, 32'hA800_0000);
		tx(2'h2, 3'h4);
		tx(2'h1, 3'h3);
		apb(1'b1, 8'h18, 32'h9000_0000);
		tx(2'h1, 3'h4);
		tx(2'h2, 3'h1);
		$display("done: stall");
		apb(1'b1, 8'h18, 32'hF800_0003);
		tx(2'h0, 3'h2);
		i_host_model.data(7'h08);
		apb(1'b0, 8'h18, 32'h0);
		check("setup end", 32'h8000_0000, rd & 32'hF800_0000);
		tx(2'h1, 3'h1);
		$display("done: setup");
		print_verdict();
	end
endmodule : tb_top
